// ===== hw/diag_pkg.sv
// Overview of operation
// RL1 - Each channel error bit is the OR of its over-temperature flag and its latched over-load flag.
// RL2 - Over-load events are latched into the error flags until a diagnosis word frame clears them.
// RL3 - The diagnosis clear of over-load flags happens after the second and before the third SCLK rise.
// RL4 - An over-temperature event sets a thermal latch that keeps the channel off until a clear command.
// RL5 - After a clear-thermal-latch command the temperature error flag is cleared only in the next frame.
// RL6 - Once cleared there, the temperature error flag latches again only after that frame's third SCLK rise.
// RL7 - The first diagnosis word after a clear command still shows failure; the host must not take it as new.
// RL8 - A persisting over-load sets the error flag again right after every clear.
// RL9 - A channel in over-current or over-temperature has its sense output switched off.
// RL10 - The sense multiplexer routes at most one channel, chosen by the select field, to the sense pin.
// RL11 - A dedicated select value disables the sense output entirely.
// RL12 - The bypass monitor result is the drain-source comparator of the selected channel, readable by the host.
// RL13 - The over-temperature flag latches even with the channel off and is cleared only by the clear command.
// RL14 - The select pattern 110 disables the sense output.
// RL15 - Writing one to bit 0 of the hardware configuration command clears all thermal latches; zero does nothing.
// RL16 - Error, over-temperature and over-load state is kept separately for each of six channels 0 to 5.
package diag_pkg;

	localparam int          NUM_CH         = 6;
	localparam int          SEL_W          = 3;
	localparam int          HW_CONFIG_COMMAND_W         = 4;
	localparam int          CTL_BIT        = 0;
	localparam int          SYNC_STAGES    = 3;
	localparam logic [SEL_W-1:0] SENSE_OFF_SEL = 3'h6;
	localparam logic [1:0]  EDGE_CLEAR     = 2'h2;
	localparam logic [1:0]  EDGE_REARM     = 2'h3;
	localparam logic [NUM_CH-1:0] FLAGS_RST = 6'h00;
	localparam logic [NUM_CH-1:0] DIAG_RST  = 6'h00;

	typedef logic [NUM_CH-1:0] ch_vec_t;
	typedef logic [SEL_W-1:0]  sel_t;

	typedef enum logic [1:0] {
		CTL_IDLE     = 2'h0,
		CTL_ARMED    = 2'h1,
		CTL_IN_FRAME = 2'h3,
		CTL_CLEARING = 2'h2
	} ctl_state_t;

endpackage : diag_pkg

// ===== hw/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,     // system clock
	input  wire logic             sys_rst_i, // async reset, high
	input  wire logic             ce_i,      // clock enable
	input  wire logic [WIDTH-1:0] async_i,   // foreign-domain input
	output logic      [WIDTH-1:0] sync_o     // settled value
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] out_ff;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end else if (ce_i) begin
			stage1_ff <= async_i;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_ff <= '0;
		end else if (ce_i) begin
			out_ff <= (stage2_ff & stage3_ff) | (out_ff & (stage2_ff | stage3_ff));
		end
	end

	assign sync_o = out_ff;

endmodule : pin_sync
`default_nettype wire

// ===== hw/sclk_edge_counter.sv
`timescale 1ns/100ps
`default_nettype none
module sclk_edge_counter (
	input  wire logic spi_sclk_i,     // link serial clock
	input  wire logic spi_csn_i,      // frame select, low in frame
	output logic      past_second_o,  // second rising edge seen
	output logic      past_third_o    // third rising edge seen
);
	import diag_pkg::*;

	logic [1:0] edge_cnt_ff;
	logic       past_second_ff;
	logic       past_third_ff;

	// frame end clears everything, so no edge after the frame is needed
	always_ff @(posedge spi_sclk_i or posedge spi_csn_i) begin
		if (spi_csn_i) begin
			edge_cnt_ff <= 2'h0;
		end else if (edge_cnt_ff != EDGE_REARM) begin
			edge_cnt_ff <= edge_cnt_ff + 2'h1;
		end
	end

	always_ff @(posedge spi_sclk_i or posedge spi_csn_i) begin
		if (spi_csn_i) begin
			past_second_ff <= 1'b0;
			past_third_ff  <= 1'b0;
		end else begin
			past_second_ff <= past_second_ff | (edge_cnt_ff == (EDGE_CLEAR - 2'h1)); // RL3
			past_third_ff  <= past_third_ff | (edge_cnt_ff == (EDGE_REARM - 2'h1));  // RL6
		end
	end

	assign past_second_o = past_second_ff;
	assign past_third_o  = past_third_ff;

endmodule : sclk_edge_counter
`default_nettype wire

// ===== hw/output_switch_diagnosis.sv
`timescale 1ns/100ps
`default_nettype none
module output_switch_diagnosis (
	input  wire logic                   clk_i,                   // system clock, 200 MHz
	input  wire logic                   sys_rst_i,               // async reset, high
	input  wire logic                   ce_i,                    // clock enable
	input  wire logic                   spi_sclk_i,              // link serial clock
	input  wire logic                   spi_csn_i,               // frame select, low in frame
	input  wire logic                   diag_word_sel_i,         // frame carries diagnosis word
	input  wire logic                   hw_config_command_write_i,            // hw config command strobe
	input  wire logic [diag_pkg::HW_CONFIG_COMMAND_W-1:0] hw_config_command_i, // hw config command data
	input  wire diag_pkg::sel_t         sense_channel_select_i,  // sense mux select
	input  wire diag_pkg::ch_vec_t      ot_event_i,              // thermal sensor trips
	input  wire diag_pkg::ch_vec_t      ol_event_i,              // over-load monitor
	input  wire diag_pkg::ch_vec_t      vds_low_i,               // vds below bypass threshold
	output diag_pkg::ch_vec_t           channel_error_flag_o,    // live error flags
	output diag_pkg::ch_vec_t           diag_word_o,             // word captured at frame start
	output diag_pkg::ch_vec_t           thermal_off_o,           // thermal latch, gate off
	output diag_pkg::ch_vec_t           sense_route_o,           // one-hot sense routing
	output logic                        sense_output_pin_en_o,   // sense pin enabled
	output logic                        bypass_monitor_result_o, // selected vds comparator
	output logic                        ctl_pending_o            // clear awaiting next frame
);
	import diag_pkg::*;

	function automatic ch_vec_t sel_onehot(input sel_t sel);
		ch_vec_t vec;
		vec = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (sel == sel_t'(i)) begin
				vec[i] = 1'b1;
			end
		end
		return vec;
	endfunction : sel_onehot

	// ------------------------------------------------------------ crossings
	logic [3*NUM_CH:0] pin_raw;
	logic [3*NUM_CH:0] pin_s;
	logic [1:0]        link_raw;
	logic [1:0]        link_s;
	logic              past_second_l;
	logic              past_third_l;

	assign pin_raw = {spi_csn_i, vds_low_i, ol_event_i, ot_event_i};

	pin_sync #(
		.WIDTH (3*NUM_CH+1)
	) u_pin_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.async_i   (pin_raw),
		.sync_o    (pin_s)
	);

	sclk_edge_counter u_edge_counter (
		.spi_sclk_i    (spi_sclk_i),
		.spi_csn_i     (spi_csn_i),
		.past_second_o (past_second_l),
		.past_third_o  (past_third_l)
	);

	assign link_raw = {past_third_l, past_second_l};

	pin_sync #(
		.WIDTH (2)
	) u_link_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.async_i   (link_raw),
		.sync_o    (link_s)
	);

	ch_vec_t ot_s;
	ch_vec_t ol_s;
	ch_vec_t vds_s;
	logic    frame_s;
	logic    past_second_s;
	logic    past_third_s;

	assign ot_s          = pin_s[NUM_CH-1:0];
	assign ol_s          = pin_s[2*NUM_CH-1:NUM_CH];
	assign vds_s         = pin_s[3*NUM_CH-1:2*NUM_CH];
	assign frame_s       = ~pin_s[3*NUM_CH];
	assign past_second_s = link_s[0];
	assign past_third_s  = link_s[1];

	// ------------------------------------------------------------ frame events
	logic frame_d_ff;
	logic past_second_d_ff;
	logic frame_start;
	logic clear_point;
	logic ctl_cmd;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// synced select reads as in-frame until csn has passed the flops
			frame_d_ff       <= 1'b1;
			past_second_d_ff <= 1'b0;
		end else if (ce_i) begin
			frame_d_ff       <= frame_s;
			past_second_d_ff <= past_second_s;
		end
	end

	assign frame_start = frame_s & ~frame_d_ff;
	assign clear_point = past_second_s & ~past_second_d_ff; // RL3
	assign ctl_cmd     = hw_config_command_write_i & hw_config_command_i[CTL_BIT]; // RL15

	// ------------------------------------------------------------ thermal latch
	ch_vec_t thermal_latch_ff;
	ch_vec_t nxt_thermal_latch;

	// a trip in the clear cycle survives the clear
	always_comb begin
		nxt_thermal_latch = thermal_latch_ff;
		if (ctl_cmd) begin
			nxt_thermal_latch = '0; // RL15
		end
		nxt_thermal_latch = nxt_thermal_latch | ot_s; // RL4 RL13 RL16
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			thermal_latch_ff <= FLAGS_RST;
		end else if (ce_i) begin
			thermal_latch_ff <= nxt_thermal_latch;
		end
	end

	// ------------------------------------------------------------ clear sequencer
	ctl_state_t ctl_state_ff;
	ctl_state_t nxt_ctl_state;

	always_comb begin
		nxt_ctl_state = ctl_state_ff;
		case (ctl_state_ff)
			CTL_IDLE: begin
				nxt_ctl_state = CTL_IDLE;
			end
			CTL_ARMED: begin
				if (frame_start) begin
					nxt_ctl_state = CTL_IN_FRAME; // RL5
				end
			end
			CTL_IN_FRAME: begin
				if (!frame_s) begin
					nxt_ctl_state = CTL_ARMED;
				end else if (clear_point) begin
					nxt_ctl_state = CTL_CLEARING;
				end
			end
			CTL_CLEARING: begin
				if (past_third_s || !frame_s) begin
					nxt_ctl_state = CTL_IDLE; // RL6
				end
			end
			default: begin
				nxt_ctl_state = CTL_IDLE;
			end
		endcase
		if (ctl_cmd) begin
			nxt_ctl_state = CTL_ARMED; // RL5
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl_state_ff <= CTL_IDLE;
		end else if (ce_i) begin
			ctl_state_ff <= nxt_ctl_state;
		end
	end

	// ------------------------------------------------------------ temperature error flag
	ch_vec_t ot_flag_ff;
	ch_vec_t nxt_ot_flag;
	logic    ot_clear;
	logic    ot_hold;

	assign ot_clear = (ctl_state_ff == CTL_IN_FRAME) & frame_s & clear_point & ~ctl_cmd; // RL5
	assign ot_hold  = (ctl_state_ff == CTL_CLEARING);

	always_comb begin
		nxt_ot_flag = ot_flag_ff;
		if (ot_clear) begin
			nxt_ot_flag = '0; // RL5
		end else if (!ot_hold) begin
			nxt_ot_flag = ot_flag_ff | ot_s; // RL6 RL13
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ot_flag_ff <= FLAGS_RST;
		end else if (ce_i) begin
			ot_flag_ff <= nxt_ot_flag;
		end
	end

	// ------------------------------------------------------------ over-load flag
	ch_vec_t ol_flag_ff;
	ch_vec_t nxt_ol_flag;
	logic    ol_clear;

	assign ol_clear = clear_point & diag_word_sel_i; // RL2 RL3

	always_comb begin
		nxt_ol_flag = ol_flag_ff;
		if (ol_clear) begin
			nxt_ol_flag = '0; // RL2
		end
		nxt_ol_flag = nxt_ol_flag | ol_s; // RL8 RL16
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ol_flag_ff <= FLAGS_RST;
		end else if (ce_i) begin
			ol_flag_ff <= nxt_ol_flag;
		end
	end

	// ------------------------------------------------------------ diagnosis word
	ch_vec_t error_flag;
	ch_vec_t diag_word_ff;

	assign error_flag = ot_flag_ff | ol_flag_ff; // RL1

	// snapshot taken at frame start, before this frame's clear point
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			diag_word_ff <= DIAG_RST;
		end else if (ce_i && frame_start) begin
			diag_word_ff <= error_flag; // RL7
		end
	end

	// ------------------------------------------------------------ sense multiplexer
	ch_vec_t route_ff;
	ch_vec_t nxt_route;
	logic    sense_en_ff;
	logic    sel_valid;

	assign sel_valid = (sense_channel_select_i != SENSE_OFF_SEL) &&
		(sense_channel_select_i < sel_t'(NUM_CH)); // RL11 RL14

	always_comb begin
		nxt_route = '0;
		if (sel_valid) begin
			nxt_route = sel_onehot(sense_channel_select_i); // RL10
		end
		nxt_route = nxt_route & ~(ol_s | thermal_latch_ff | ot_s); // RL9
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			route_ff    <= '0;
			sense_en_ff <= 1'b0;
		end else if (ce_i) begin
			route_ff    <= nxt_route;
			sense_en_ff <= |nxt_route;
		end
	end

	// ------------------------------------------------------------ bypass monitor
	logic bypass_ff;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bypass_ff <= 1'b0;
		end else if (ce_i) begin
			bypass_ff <= sel_valid & |(vds_s & sel_onehot(sense_channel_select_i)); // RL12
		end
	end

	// ------------------------------------------------------------ outputs
	logic pending_ff;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pending_ff <= 1'b0;
		end else if (ce_i) begin
			pending_ff <= (nxt_ctl_state == CTL_ARMED) || (nxt_ctl_state == CTL_IN_FRAME);
		end
	end

	assign channel_error_flag_o    = error_flag;
	assign diag_word_o             = diag_word_ff;
	assign thermal_off_o           = thermal_latch_ff; // RL4
	assign sense_route_o           = route_ff;
	assign sense_output_pin_en_o   = sense_en_ff;
	assign bypass_monitor_result_o = bypass_ff;
	assign ctl_pending_o           = pending_ff;

endmodule : output_switch_diagnosis
`default_nettype wire

// ===== testbench/output_switch_diagnosis_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module output_switch_diagnosis_monitor (
	input wire logic                    clk_i,                   // clock
	input wire logic                    sys_rst_i,               // reset
	input wire logic                    ce_i,                    // enable
	input wire logic                    spi_sclk_i,              // link clock
	input wire logic                    spi_csn_i,               // frame select
	input wire logic                    diag_word_sel_i,         // diag frame
	input wire logic                    hw_config_command_write_i,            // cmd strobe
	input wire logic [diag_pkg::HW_CONFIG_COMMAND_W-1:0] hw_config_command_i, // cmd data
	input wire diag_pkg::sel_t          sense_channel_select_i,  // mux select
	input wire diag_pkg::ch_vec_t       ot_event_i,              // thermal trips
	input wire diag_pkg::ch_vec_t       ol_event_i,              // over-load
	input wire diag_pkg::ch_vec_t       vds_low_i,               // vds low
	input wire diag_pkg::ch_vec_t       channel_error_flag_o,    // error flags
	input wire diag_pkg::ch_vec_t       diag_word_o,             // diag word
	input wire diag_pkg::ch_vec_t       thermal_off_o,           // thermal latch
	input wire diag_pkg::ch_vec_t       sense_route_o,           // sense routing
	input wire logic                    sense_output_pin_en_o,   // sense enable
	input wire logic                    bypass_monitor_result_o, // bypass bit
	input wire logic                    ctl_pending_o            // clear pending
);
	import diag_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_route_one_hot: assert property ($onehot0(sense_route_o))
		else $error("sense routed to more than one channel");
	a_sense_sel_off: assert property (sense_channel_select_i >= SENSE_OFF_SEL
		&& $past(sense_channel_select_i, 6) >= SENSE_OFF_SEL
		|-> !sense_output_pin_en_o && !bypass_monitor_result_o)
		else $error("sense or bypass active with select off");
	a_fault_cuts_sense: assert property (((ol_event_i | ot_event_i)
		& $past(ol_event_i | ot_event_i, 6) & sense_route_o) == 0)
		else $error("faulty channel still routed to sense");
	a_ot_sets_latch: assert property ((ot_event_i & $past(ot_event_i, 5)
		& ~thermal_off_o) == 0)
		else $error("thermal latch not set by over-temperature");
	a_latch_hold: assert property (($past(thermal_off_o) & ~thermal_off_o) != 0
		|-> $past(hw_config_command_write_i && hw_config_command_i[CTL_BIT]))
		else $error("thermal latch dropped without clear command");
	a_clear_cmd: assert property (hw_config_command_write_i && hw_config_command_i[CTL_BIT]
		&& ot_event_i == 0 && $past(ot_event_i, 4) == 0 |=> thermal_off_o == 0)
		else $error("clear command left thermal latch set");
	a_pending_set: assert property (hw_config_command_write_i && hw_config_command_i[CTL_BIT]
		|=> ctl_pending_o)
		else $error("clear command not pending");
	a_pending_quiet: assert property (!ctl_pending_o
		&& !(hw_config_command_write_i && hw_config_command_i[CTL_BIT]) |=> !ctl_pending_o)
		else $error("pending raised without clear command");
	a_flag_drop_frame: assert property (($past(channel_error_flag_o)
		& ~channel_error_flag_o) != 0 |-> !$past(spi_csn_i, 5))
		else $error("error flag cleared outside a frame");
	a_word_at_start: assert property (diag_word_o != $past(diag_word_o)
		|-> !spi_csn_i && $past(spi_csn_i, 7))
		else $error("diagnosis word changed away from frame start");
endmodule : output_switch_diagnosis_monitor
bind output_switch_diagnosis output_switch_diagnosis_monitor u_mon (.clk_i, .sys_rst_i,
	.ce_i, .spi_sclk_i, .spi_csn_i, .diag_word_sel_i, .hw_config_command_write_i, .hw_config_command_i,
	.sense_channel_select_i, .ot_event_i, .ol_event_i, .vds_low_i, .channel_error_flag_o,
	.diag_word_o, .thermal_off_o, .sense_route_o, .sense_output_pin_en_o,
	.bypass_monitor_result_o, .ctl_pending_o);
`default_nettype wire

// ===== testbench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input  wire logic start_i,    // begin a frame
	output logic      spi_csn_o,  // frame select
	output logic      spi_sclk_o, // link clock, still outside frames
	output logic      done_o      // frame over
);
	initial begin
		spi_csn_o = 1'b1;
		spi_sclk_o = 1'b0;
		done_o = 1'b0;
		forever begin
			@(posedge start_i);
			done_o = 1'b0;
			#3 spi_csn_o = 1'b0;
			repeat (3) begin
				#16 spi_sclk_o = 1'b1;
				#16 spi_sclk_o = 1'b0;
			end
			#16 spi_csn_o = 1'b1;
			// csn stays high long enough to be seen between frames
			#30 done_o = 1'b1;
		end
	end
endmodule : spi_host_model
`default_nettype wire

// ===== testbench/output_switch_diagnosis_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module output_switch_diagnosis_bench;
	import diag_pkg::*;
	logic clk_i, sys_rst_i, ce_i, spi_sclk_i, spi_csn_i, diag_word_sel_i, hw_config_command_write_i;
	logic [HW_CONFIG_COMMAND_W-1:0] hw_config_command_i;
	sel_t              sense_channel_select_i;
	ch_vec_t           ot_event_i, ol_event_i, vds_low_i, at2, at3, exp_route;
	ch_vec_t           channel_error_flag_o, diag_word_o, thermal_off_o, sense_route_o;
	logic              sense_output_pin_en_o, bypass_monitor_result_o, ctl_pending_o;
	logic              start, done;
	int                fail_count, num_checks, nrise;
	output_switch_diagnosis u_dut (.clk_i, .sys_rst_i, .ce_i, .spi_sclk_i, .spi_csn_i,
		.diag_word_sel_i, .hw_config_command_write_i, .hw_config_command_i, .sense_channel_select_i,
		.ot_event_i, .ol_event_i, .vds_low_i, .channel_error_flag_o, .diag_word_o,
		.thermal_off_o, .sense_route_o, .sense_output_pin_en_o, .bypass_monitor_result_o,
		.ctl_pending_o);
	spi_host_model u_host (.start_i(start), .spi_csn_o(spi_csn_i), .spi_sclk_o(spi_sclk_i),
		.done_o(done));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// flags seen on the link edges around the clear point
	always @(posedge spi_sclk_i) begin
		nrise++;
		if (nrise == 2) at2 = channel_error_flag_o;
		if (nrise == 3) at3 = channel_error_flag_o;
	end
	task automatic summarize();
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wt
	task automatic ctl(input logic [HW_CONFIG_COMMAND_W-1:0] c);
		@(negedge clk_i);
		hw_config_command_i = c;
		hw_config_command_write_i = 1'b1;
		@(negedge clk_i);
		hw_config_command_write_i = 1'b0;
	endtask : ctl
	task automatic frame(input logic d);
		int t;
		@(negedge clk_i);
		diag_word_sel_i = d;
		nrise = 0;
		start = 1'b1;
		wt(1);
		start = 1'b0;
		t = 0;
		while (done !== 1'b1 && t < 200) begin
			t++;
			wt(1);
		end
		if (t >= 200) begin
			fail_count++;
			summarize();
		end
	endtask : frame
	initial begin
		{ce_i, sys_rst_i} = 2'b11;
		{diag_word_sel_i, hw_config_command_write_i, start} = '0;
		{hw_config_command_i, sense_channel_select_i} = '0;
		{ot_event_i, ol_event_i, vds_low_i} = '0;
		wt(5);
		sys_rst_i = 1'b0;
		wt(2);
		`CK("flags", 6'h00, channel_error_flag_o)
		ol_event_i = 6'h04;
		sense_channel_select_i = 3'h2;
		wt(8);
		`CK("ol flag", 6'h04, channel_error_flag_o)
		`CK("ol sense", 6'h00, sense_route_o)
		ol_event_i = 6'h00;
		frame(1'b0);
		`CK("kept", 6'h04, channel_error_flag_o)
		frame(1'b1);
		`CK("rise2", 6'h04, at2)
		`CK("rise3", 6'h00, at3)
		`CK("word", 6'h04, diag_word_o)
		ol_event_i = 6'h20;
		wt(8);
		frame(1'b1);
		`CK("relatch", 6'h20, channel_error_flag_o)
		ol_event_i = 6'h00;
		wt(8);
		frame(1'b1);
		ot_event_i = 6'h02;
		wt(8);
		`CK("ot off", 6'h02, thermal_off_o)
		`CK("ot flag", 6'h02, channel_error_flag_o)
		ot_event_i = 6'h00;
		ctl(4'h0);
		frame(1'b1);
		`CK("ot kept", 6'h02, channel_error_flag_o)
		`CK("latch kept", 6'h02, thermal_off_o)
		ctl(4'h1);
		`CK("latch clr", 6'h00, thermal_off_o)
		`CK("pending", 1'b1, ctl_pending_o)
		`CK("cmd frame", 6'h02, channel_error_flag_o)
		frame(1'b1);
		// the stale report after a clear is expected, not a new fault
		`CK("first word", 6'h02, diag_word_o)
		`CK("ot clr", 6'h00, channel_error_flag_o)
		`CK("pend done", 1'b0, ctl_pending_o)
		vds_low_i = 6'h15;
		for (int s = 0; s < 8; s++) begin
			sense_channel_select_i = sel_t'(s);
			exp_route = (s < NUM_CH) ? ch_vec_t'(1 << s) : '0;
			wt(8);
			`CK("route", exp_route, sense_route_o)
			`CK("pin en", exp_route != 0, sense_output_pin_en_o)
			`CK("bypass", |(exp_route & vds_low_i), bypass_monitor_result_o)
		end
		ce_i = 1'b0;
		ol_event_i = 6'h08;
		wt(8);
		`CK("ce frozen", 6'h00, channel_error_flag_o)
		ce_i = 1'b1;
		wt(8);
		`CK("ce run", 6'h08, channel_error_flag_o)
		summarize();
	end
endmodule : output_switch_diagnosis_bench
`default_nettype wire
